//--- usbsq_defs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef USBSQ_DEFS_SVH
`define USBSQ_DEFS_SVH

`define USBSQ_ADDR_W           8
`define USBSQ_DATA_W           32

`define USBSQ_OFF_CMD          8'h00
`define USBSQ_OFF_CTRL         8'h04
`define USBSQ_OFF_MON          8'h08
`define USBSQ_OFF_STAT         8'h0c
`define USBSQ_OFF_MASK         8'h10

`define USBSQ_CMD_LSB          0
`define USBSQ_CMD_MSB          1
`define USBSQ_CMD_RUN          2'h1
`define USBSQ_CMD_SLEEP        2'h2

`define USBSQ_CTRL_SPD_LSB     0
`define USBSQ_CTRL_SPD_MSB     1
`define USBSQ_CTRL_RWK_BIT     2

`define USBSQ_MON_HST_LSB      0
`define USBSQ_MON_HST_MSB      2
`define USBSQ_MON_XSEL_LSB     3
`define USBSQ_MON_XSEL_MSB     4
`define USBSQ_MON_TERM_BIT     5
`define USBSQ_MON_OPM_LSB      6
`define USBSQ_MON_OPM_MSB      7
`define USBSQ_MON_DISC_BIT     8
`define USBSQ_MON_RWK_BIT      9
`define USBSQ_MON_BUSY_BIT     10

`define USBSQ_STAT_SUSP_BIT    0
`define USBSQ_STAT_PKT_BIT     1
`define USBSQ_STAT_W           2

`define USBSQ_RST_SPEED        2'h1
`define USBSQ_RST_MASK         2'h0

`define USBSQ_CLK_NS           40
`define USBSQ_CEIL_CYC(ns)     (((ns) + `USBSQ_CLK_NS - 1) / `USBSQ_CLK_NS)

`define USBSQ_HS_SOF_MIN_NS    120000
`define USBSQ_HS_SOF_MAX_NS    130000
`define USBSQ_FL_PKT_MIN_NS    900000
`define USBSQ_FL_PKT_MAX_NS    1100000
`define USBSQ_REARM_MIN_NS     5000000

`define USBSQ_TMR_W            17
`define USBSQ_HS_SOF_CYC       (`USBSQ_CEIL_CYC(`USBSQ_HS_SOF_MIN_NS) + 1)
`define USBSQ_FL_PKT_CYC       (`USBSQ_CEIL_CYC(`USBSQ_FL_PKT_MIN_NS) + 1)
`define USBSQ_REARM_CYC        (`USBSQ_CEIL_CYC(`USBSQ_REARM_MIN_NS) + 1)

`endif

//--- usbsq_pkg.sv
// Types shared by the port state sequencer and its timer
package usbsq_pkg;

	typedef enum logic [5:0] {
		ST_IDLE  = 6'h01,
		ST_RUNW  = 6'h02,
		ST_RUN   = 6'h04,
		ST_DRAIN = 6'h08,
		ST_XSW   = 6'h10,
		ST_SWAIT = 6'h20
	} usbsq_state_t;

	typedef enum logic [2:0] {
		HST_IDLE  = 3'h0,
		HST_RUN   = 3'h3,
		HST_SLEEP = 3'h4
	} usbsq_hst_t;

	typedef enum logic [1:0] {
		SPD_HS = 2'h0,
		SPD_FS = 2'h1,
		SPD_LS = 2'h2
	} usbsq_spd_t;

	typedef enum logic [1:0] {
		OPM_NORMAL = 2'h0,
		OPM_SLEEP  = 2'h3
	} usbsq_opm_t;

	typedef struct packed {
		logic [1:0] xsel;
		logic       term_fs;
		usbsq_opm_t opm;
	} usbsq_xcvr_t;

	typedef struct packed {
		logic [16:0] cnt;
	} usbsq_tmr_t;

	typedef struct packed {
		usbsq_state_t st;
		usbsq_hst_t   hst;
		usbsq_xcvr_t  xcvr;
		logic         disc_en;
		logic         rwk_en;
		logic [1:0]   speed;
		logic         rwk_permit;
		logic [1:0]   stat;
		logic [1:0]   mask;
		logic         irq;
		logic         sof;
		logic         keep;
		logic [31:0]  rdata;
	} usbsq_regs_t;

endpackage

//--- usbsq_timer.sv
// Down-counting interval timer with a load and a one-cycle expiry flag
`include "usbsq_defs.svh"

module usbsq_timer (
	// Clock and reset
	input  wire logic                    clk,
	input  wire logic                    rst,
	// Control
	input  wire logic                    load,
	input  wire logic [`USBSQ_TMR_W-1:0] load_val,
	input  wire logic                    stop,
	// Expiry
	output logic                         done
);

	usbsq_pkg::usbsq_tmr_t r;
	usbsq_pkg::usbsq_tmr_t n;

	always_comb begin
		n = r;
		if (stop) begin
			n.cnt = '0;
		end else if (load) begin
			n.cnt = load_val;
		end else if (r.cnt != '0) begin
			n.cnt = r.cnt - 17'h00001;
		end
	end

	// Flag is raised while the count is one, the step before it rests at zero, so it lasts one cycle
	assign done = (r.cnt == 17'h00001);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

endmodule

//--- usbsq_seq.sv
// Host port sequencer for entry to the operational and suspend states
//
// Contract
// - At high speed, first start-of-frame comes 120 to 130 us after run command.
// - At full or low speed, first SOF or keep-alive 0.9 to 1.1 ms later.
// - Host state monitor shows suspend in the cycle the sleep command lands.
// - Sleep command disables disconnect and remote-wakeup detection at once.
// - High speed: await idle bus, switch select and termination to FS, then sleep.
// - Full speed: await transaction end, then sleep; transceiver select stays FS.
// - More than 5 ms after sleep mode, disconnect detection returns.
// - Remote-wakeup detection returns with it only if its permit bit is set.
// - Suspend done flag rises together with detection re-enable.
// - Run command sets monitor to operational and op mode to normal.
// - Run command enables disconnect detection in the same cycle.
`include "usbsq_defs.svh"

module usbsq_seq #(
	parameter int P_FL_PKT_CYC = `USBSQ_FL_PKT_CYC,
	parameter int P_REARM_CYC  = `USBSQ_REARM_CYC
) (
	// Clock and reset
	input  wire logic                      CLK,
	input  wire logic                      SYS_RST,
	// Register port
	input  wire logic [`USBSQ_ADDR_W-1:0]  REG_ADDR,
	input  wire logic [`USBSQ_DATA_W-1:0]  REG_WDATA,
	input  wire logic                      REG_WR,
	input  wire logic                      REG_RD,
	output logic      [`USBSQ_DATA_W-1:0]  REG_RDATA,
	// Link activity from the serial engine
	input  wire logic                      TRANS_BUSY,
	input  wire logic                      BUS_ACTIVE,
	// Transceiver control
	output logic      [1:0]                XCVR_SEL,
	output logic                           TERM_SEL,
	output logic      [1:0]                OP_MODE,
	// Port state and detection gates
	output logic      [2:0]                HOST_STATE,
	output logic                           DISC_DET_EN,
	output logic                           RWK_DET_EN,
	// First packet requests to the frame generator
	output logic                           FIRST_SOF,
	output logic                           FIRST_KEEPALIVE,
	// Interrupt
	output logic                           IRQ
);

	localparam logic [`USBSQ_TMR_W-1:0] HS_SOF_VAL =
		`USBSQ_TMR_W'(`USBSQ_HS_SOF_CYC);
	localparam logic [`USBSQ_TMR_W-1:0] FL_PKT_VAL =
		`USBSQ_TMR_W'(P_FL_PKT_CYC);
	localparam logic [`USBSQ_TMR_W-1:0] REARM_VAL =
		`USBSQ_TMR_W'(P_REARM_CYC);

	usbsq_pkg::usbsq_regs_t r;
	usbsq_pkg::usbsq_regs_t n;

	logic                    tmr_load;
	logic [`USBSQ_TMR_W-1:0] tmr_val;
	logic                    tmr_stop;
	logic                    tmr_done;

	logic                    wr_cmd;
	logic                    rd_stat;
	logic [1:0]              cmd;
	logic [1:0]              stat_set;
	logic                    in_sleep_seq;

	function automatic logic hit(
		input logic [`USBSQ_ADDR_W-1:0] addr,
		input logic [`USBSQ_ADDR_W-1:0] off
	);
		hit = (addr == off);
	endfunction

	function automatic logic [31:0] mon_word(
		input usbsq_pkg::usbsq_regs_t s
	);
		logic [31:0] w;
		w = 32'h00000000;
		w[`USBSQ_MON_HST_MSB:`USBSQ_MON_HST_LSB]   = s.hst;
		w[`USBSQ_MON_XSEL_MSB:`USBSQ_MON_XSEL_LSB] = s.xcvr.xsel;
		w[`USBSQ_MON_TERM_BIT]                     = s.xcvr.term_fs;
		w[`USBSQ_MON_OPM_MSB:`USBSQ_MON_OPM_LSB]   = s.xcvr.opm;
		w[`USBSQ_MON_DISC_BIT]                     = s.disc_en;
		w[`USBSQ_MON_RWK_BIT]                      = s.rwk_en;
		w[`USBSQ_MON_BUSY_BIT]                     = (s.st != usbsq_pkg::ST_IDLE)
			&& (s.st != usbsq_pkg::ST_RUN);
		mon_word = w;
	endfunction

	assign wr_cmd  = REG_WR && hit(REG_ADDR, `USBSQ_OFF_CMD);
	assign rd_stat = REG_RD && hit(REG_ADDR, `USBSQ_OFF_STAT);
	assign cmd     = REG_WDATA[`USBSQ_CMD_MSB:`USBSQ_CMD_LSB];

	// Suspend entry ignores a repeated sleep command until it completes; a run command still overrides it
	assign in_sleep_seq = (r.st == usbsq_pkg::ST_DRAIN)
		|| (r.st == usbsq_pkg::ST_XSW)
		|| (r.st == usbsq_pkg::ST_SWAIT);

	always_comb begin
		n        = r;
		tmr_load = 1'b0;
		tmr_val  = '0;
		tmr_stop = 1'b0;
		stat_set = 2'h0;
		n.sof    = 1'b0;
		n.keep   = 1'b0;

		// Register writes
		if (REG_WR && hit(REG_ADDR, `USBSQ_OFF_CTRL)) begin
			n.speed      = REG_WDATA[`USBSQ_CTRL_SPD_MSB:`USBSQ_CTRL_SPD_LSB];
			n.rwk_permit = REG_WDATA[`USBSQ_CTRL_RWK_BIT];
		end
		if (REG_WR && hit(REG_ADDR, `USBSQ_OFF_MASK)) begin
			n.mask = REG_WDATA[`USBSQ_STAT_W-1:0];
		end

		// Sequencer
		unique case (r.st)
			usbsq_pkg::ST_IDLE, usbsq_pkg::ST_RUNW, usbsq_pkg::ST_RUN: begin
				if (r.st == usbsq_pkg::ST_RUNW && tmr_done) begin
					n.st = usbsq_pkg::ST_RUN;
					if (r.speed == usbsq_pkg::SPD_LS) begin
						n.keep = 1'b1;
					end else begin
						n.sof = 1'b1;
					end
					stat_set[`USBSQ_STAT_PKT_BIT] = 1'b1;
				end
			end
			usbsq_pkg::ST_DRAIN: begin
				if (r.speed == usbsq_pkg::SPD_HS) begin
					// Wait for both the transaction and any trailing bus traffic
					if (!TRANS_BUSY && !BUS_ACTIVE) begin
						n.xcvr.xsel    = usbsq_pkg::SPD_FS;
						n.xcvr.term_fs = 1'b1;
						n.st           = usbsq_pkg::ST_XSW;
					end
				end else if (!TRANS_BUSY) begin
					n.xcvr.opm = usbsq_pkg::OPM_SLEEP;
					tmr_load   = 1'b1;
					tmr_val    = REARM_VAL;
					n.st       = usbsq_pkg::ST_SWAIT;
				end
			end
			usbsq_pkg::ST_XSW: begin
				// Select and termination settle a cycle before power-down
				n.xcvr.opm = usbsq_pkg::OPM_SLEEP;
				tmr_load   = 1'b1;
				tmr_val    = REARM_VAL;
				n.st       = usbsq_pkg::ST_SWAIT;
			end
			usbsq_pkg::ST_SWAIT: begin
				if (tmr_done) begin
					n.disc_en = 1'b1;
					n.rwk_en  = r.rwk_permit;
					stat_set[`USBSQ_STAT_SUSP_BIT] = 1'b1;
					n.st      = usbsq_pkg::ST_IDLE;
				end
			end
			default: begin
				n.st = usbsq_pkg::ST_IDLE;
			end
		endcase

		// Commands override the sequencer, sleep only outside suspend entry; a new run restarts the timer
		if (wr_cmd && cmd == `USBSQ_CMD_RUN) begin
			n.hst      = usbsq_pkg::HST_RUN;
			n.xcvr.opm = usbsq_pkg::OPM_NORMAL;
			n.disc_en  = 1'b1;
			n.rwk_en   = 1'b0;
			// Transceiver follows the attached speed, so an HS suspend switches
			n.xcvr.xsel    = r.speed;
			n.xcvr.term_fs = (r.speed != usbsq_pkg::SPD_HS);
			n.st       = usbsq_pkg::ST_RUNW;
			tmr_load   = 1'b1;
			if (r.speed == usbsq_pkg::SPD_HS) begin
				tmr_val = HS_SOF_VAL;
			end else begin
				tmr_val = FL_PKT_VAL;
			end
		end else if (wr_cmd && cmd == `USBSQ_CMD_SLEEP && !in_sleep_seq) begin
			n.hst     = usbsq_pkg::HST_SLEEP;
			n.disc_en = 1'b0;
			n.rwk_en  = 1'b0;
			n.st      = usbsq_pkg::ST_DRAIN;
			tmr_stop  = 1'b1;
		end

		// Sticky status, cleared by reading it; a new event wins over the clear
		n.stat = (rd_stat ? 2'h0 : r.stat) | stat_set;
		n.irq  = |(n.stat & n.mask);

		// Read data stands in the cycle after the strobe only
		n.rdata = 32'h00000000;
		if (REG_RD) begin
			if (hit(REG_ADDR, `USBSQ_OFF_CTRL)) begin
				n.rdata[`USBSQ_CTRL_SPD_MSB:`USBSQ_CTRL_SPD_LSB] = r.speed;
				n.rdata[`USBSQ_CTRL_RWK_BIT] = r.rwk_permit;
			end else if (hit(REG_ADDR, `USBSQ_OFF_MON)) begin
				n.rdata = mon_word(r);
			end else if (hit(REG_ADDR, `USBSQ_OFF_STAT)) begin
				n.rdata[`USBSQ_STAT_W-1:0] = r.stat;
			end else if (hit(REG_ADDR, `USBSQ_OFF_MASK)) begin
				n.rdata[`USBSQ_STAT_W-1:0] = r.mask;
			end
		end
	end

	usbsq_timer u_timer (
		.clk      (CLK),
		.rst      (SYS_RST),
		.load     (tmr_load),
		.load_val (tmr_val),
		.stop     (tmr_stop),
		.done     (tmr_done)
	);

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			r              <= '0;
			r.st           <= usbsq_pkg::ST_IDLE;
			r.hst          <= usbsq_pkg::HST_IDLE;
			r.xcvr.xsel    <= usbsq_pkg::SPD_FS;
			r.xcvr.term_fs <= 1'b1;
			r.xcvr.opm     <= usbsq_pkg::OPM_NORMAL;
			r.speed        <= `USBSQ_RST_SPEED;
			r.mask         <= `USBSQ_RST_MASK;
		end else begin
			r <= n;
		end
	end

	assign REG_RDATA       = r.rdata;
	assign XCVR_SEL        = r.xcvr.xsel;
	assign TERM_SEL        = r.xcvr.term_fs;
	assign OP_MODE         = r.xcvr.opm;
	assign HOST_STATE      = r.hst;
	assign DISC_DET_EN     = r.disc_en;
	assign RWK_DET_EN      = r.rwk_en;
	assign FIRST_SOF       = r.sof;
	assign FIRST_KEEPALIVE = r.keep;
	assign IRQ             = r.irq;

endmodule

//--- usbsq_peer.sv
// Attached peripheral and link activity model
module usbsq_peer #(
	parameter int P_RECOG_CYC = 8
) (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Traffic request
	input  wire logic       go,
	input  wire logic [7:0] len,
	// Host transceiver mode
	input  wire logic [1:0] op_mode,
	// Activity and line state
	output logic            trans_busy,
	output logic            bus_active,
	output logic      [1:0] line_condition
);
	logic [7:0] left_r;
	logic [9:0] idle_r;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			left_r <= 8'h0;
			idle_r <= 10'h0;
		end else begin
			left_r <= go ? len : left_r - {7'h0, left_r != 8'h0};
			idle_r <= (op_mode == 2'h3) ? idle_r + {9'h0, ~&idle_r} : 10'h0;
		end
	end
	// Activity trails the transaction, so HS must wait longer than FS
	assign trans_busy = left_r > 8'h2;
	assign bus_active = left_r != 8'h0;
	// J outside power-down; in power-down SE0 until suspend is seen, then FS idle J
	assign line_condition = (op_mode == 2'h3 && idle_r <= P_RECOG_CYC) ? 2'h0 : 2'h1;
endmodule

//--- usbsq_seq_monitor.sv
// Port timing checker for the host port sequencer
`include "usbsq_defs.svh"
module usbsq_seq_monitor #(
	parameter int P_FL_PKT_CYC = `USBSQ_FL_PKT_CYC,
	parameter int P_REARM_CYC  = `USBSQ_REARM_CYC
) (
	// Clock and reset
	input wire logic        CLK,
	input wire logic        SYS_RST,
	// Register port
	input wire logic [7:0]  REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic        REG_WR,
	// Link and transceiver
	input wire logic        TRANS_BUSY,
	input wire logic [1:0]  XCVR_SEL,
	input wire logic        TERM_SEL,
	input wire logic [1:0]  OP_MODE,
	// Port state
	input wire logic [2:0]  HOST_STATE,
	input wire logic        DISC_DET_EN,
	input wire logic        RWK_DET_EN,
	input wire logic        FIRST_SOF,
	input wire logic        FIRST_KEEPALIVE
);
	default clocking @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	logic        run_wr, slp_wr;
	logic [31:0] run_cnt_r, run_cnt_nxt, pd_cnt_r, pd_cnt_nxt;
	always_comb begin
		run_wr = REG_WR && REG_ADDR == `USBSQ_OFF_CMD && REG_WDATA[1:0] == 2'h1;
		slp_wr = REG_WR && REG_ADDR == `USBSQ_OFF_CMD && REG_WDATA[1:0] == 2'h2;
		run_cnt_nxt = run_wr ? 32'h1 : run_cnt_r + 32'h1;
		pd_cnt_nxt = (OP_MODE == 2'h3) ? pd_cnt_r + 32'h1 : 32'h0;
	end
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			run_cnt_r <= 32'h0;
			pd_cnt_r <= 32'h0;
		end else begin
			run_cnt_r <= run_cnt_nxt;
			pd_cnt_r <= pd_cnt_nxt;
		end
	end
	a_run_entry: assert property (
		run_wr |=> HOST_STATE == 3'h3 && OP_MODE == 2'h0 && DISC_DET_EN)
		else $error("run entry wrong");
	a_sleep_entry: assert property (
		slp_wr |=> HOST_STATE == 3'h4 && !DISC_DET_EN && !RWK_DET_EN)
		else $error("sleep entry wrong");
	a_pd_select: assert property (
		$rose(OP_MODE == 2'h3) |-> XCVR_SEL != 2'h0 && TERM_SEL
		&& $past(XCVR_SEL) != 2'h0 && $past(TERM_SEL))
		else $error("power-down before FS select");
	a_pd_idle: assert property (
		$rose(OP_MODE == 2'h3) |-> !$past(TRANS_BUSY))
		else $error("power-down during transaction");
	a_rearm_time: assert property (
		$rose(DISC_DET_EN) && HOST_STATE == 3'h4 |-> pd_cnt_r == P_REARM_CYC)
		else $error("detection rearm time wrong");
	a_rearm_hold: assert property (
		HOST_STATE == 3'h4 && OP_MODE == 2'h3 && pd_cnt_r < P_REARM_CYC
		|-> !DISC_DET_EN) else $error("detection rearmed early");
	a_rwk_pair: assert property (
		$rose(RWK_DET_EN) |-> $rose(DISC_DET_EN) && HOST_STATE == 3'h4)
		else $error("wakeup detect apart from disconnect");
	a_sof_time: assert property (
		FIRST_SOF |-> run_cnt_r == 32'hbba || run_cnt_r == P_FL_PKT_CYC + 1)
		else $error("first frame time wrong");
	a_keep_time: assert property (
		FIRST_KEEPALIVE |-> run_cnt_r == P_FL_PKT_CYC + 1 && !FIRST_SOF)
		else $error("first keep-alive time wrong");
endmodule
bind usbsq_seq usbsq_seq_monitor #(
	.P_FL_PKT_CYC(P_FL_PKT_CYC), .P_REARM_CYC(P_REARM_CYC)
) usbsq_seq_monitor_i (
	.CLK(CLK), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR),
	.REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .TRANS_BUSY(TRANS_BUSY),
	.XCVR_SEL(XCVR_SEL), .TERM_SEL(TERM_SEL), .OP_MODE(OP_MODE),
	.HOST_STATE(HOST_STATE), .DISC_DET_EN(DISC_DET_EN),
	.RWK_DET_EN(RWK_DET_EN), .FIRST_SOF(FIRST_SOF),
	.FIRST_KEEPALIVE(FIRST_KEEPALIVE)
);

//--- tb_top.sv
// Self-checking bench for the host port sequencer
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int FL = 20;
	localparam int RA = 30;
	logic        CLK, SYS_RST, REG_WR, REG_RD, TRANS_BUSY, BUS_ACTIVE;
	logic        TERM_SEL, DISC_DET_EN, RWK_DET_EN, FIRST_SOF;
	logic        FIRST_KEEPALIVE, IRQ, go, ka;
	logic [7:0]  REG_ADDR, len;
	logic [31:0] REG_WDATA, REG_RDATA;
	logic [1:0]  XCVR_SEL, OP_MODE, line_cond;
	logic [2:0]  HOST_STATE;
	int          mismatches, checked, n;
	usbsq_seq #(.P_FL_PKT_CYC(FL), .P_REARM_CYC(RA)) usbsq_seq_i (
		.CLK(CLK), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR),
		.REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
		.REG_RDATA(REG_RDATA), .TRANS_BUSY(TRANS_BUSY),
		.BUS_ACTIVE(BUS_ACTIVE), .XCVR_SEL(XCVR_SEL), .TERM_SEL(TERM_SEL),
		.OP_MODE(OP_MODE), .HOST_STATE(HOST_STATE),
		.DISC_DET_EN(DISC_DET_EN), .RWK_DET_EN(RWK_DET_EN),
		.FIRST_SOF(FIRST_SOF), .FIRST_KEEPALIVE(FIRST_KEEPALIVE), .IRQ(IRQ)
	);
	usbsq_peer usbsq_peer_i (
		.clk(CLK), .rst(SYS_RST), .go(go), .len(len), .op_mode(OP_MODE),
		.trans_busy(TRANS_BUSY), .bus_active(BUS_ACTIVE),
		.line_condition(line_cond)
	);
	initial begin
		CLK = 1'b0;
		forever #20 CLK = ~CLK;
	end
	task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic results;
		if (mismatches == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// A gap cycle follows each write so strobes never toggle in one step
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WR <= 1'b1;
		@(posedge CLK);
		REG_WR <= 1'b0;
		@(posedge CLK);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		REG_ADDR <= a;
		REG_RD <= 1'b1;
		@(posedge CLK);
		REG_RD <= 1'b0;
		#1 cmp(REG_RDATA, e);
		@(posedge CLK);
	endtask
	// Counts cycles until an output shows; n0 numbers the first cycle seen
	task automatic wait_on(input int sel, input int n0, input int lim);
		n = n0;
		#1;
		while ((sel == 0 && FIRST_SOF !== 1'b1 && FIRST_KEEPALIVE !== 1'b1)
			|| (sel == 1 && OP_MODE !== 2'h3)
			|| (sel == 2 && DISC_DET_EN !== 1'b1)) begin
			if (n >= lim) begin
				mismatches++;
				results;
			end
			@(posedge CLK);
			#1;
			n++;
		end
		ka = FIRST_KEEPALIVE;
	endtask
	task automatic trip(input logic [1:0] spd, input logic pmt,
		input logic [1:0] msk);
		logic [1:0] fs;
		fs = (spd == 2'h2) ? 2'h2 : 2'h1;
		wr(8'h10, {30'h0, msk});
		wr(8'h04, {29'h0, pmt, spd});
		wr(8'h00, 32'h1);
		wait_on(0, 2, 4000);
		cmp(n, spd == 2'h0 ? 32'hbba : FL + 1);
		cmp(ka, spd == 2'h2);
		cmp({HOST_STATE, OP_MODE, DISC_DET_EN}, 6'h19);
		cmp({XCVR_SEL, TERM_SEL}, {spd, spd != 2'h0});
		cmp(IRQ, msk[1]);
		@(posedge CLK);
		rd(8'h0c, 32'h2);
		go <= 1'b1;
		len <= 8'h6;
		wr(8'h00, 32'h2);
		go <= 1'b0;
		wait_on(1, 2, 60);
		cmp(n, spd == 2'h0 ? 32'ha : 32'h7);
		cmp({HOST_STATE, XCVR_SEL, TERM_SEL}, {3'h4, fs, 1'b1});
		cmp({DISC_DET_EN, RWK_DET_EN, line_cond}, 4'h0);
		@(posedge CLK);
		// A repeat while power-down waits would restart the sequence if obeyed
		wr(8'h00, 32'h2);
		wait_on(2, 3, 200);
		cmp(n, RA);
		cmp({RWK_DET_EN, IRQ}, {pmt, msk[0]});
		cmp(line_cond, 2'h1);
		@(posedge CLK);
		rd(8'h08, {22'h0, pmt, 4'hf, fs, 3'h4});
		rd(8'h0c, 32'h1);
		rd(8'h0c, 32'h0);
	endtask
	initial begin
		SYS_RST = 1'b1;
		REG_WR = 1'b0;
		REG_RD = 1'b0;
		REG_ADDR = 8'h0;
		REG_WDATA = 32'h0;
		go = 1'b0;
		len = 8'h0;
		mismatches = 0;
		checked = 0;
		repeat (4) @(posedge CLK);
		SYS_RST <= 1'b0;
		@(posedge CLK);
		#1;
		cmp({HOST_STATE, OP_MODE, XCVR_SEL, TERM_SEL, DISC_DET_EN,
			RWK_DET_EN, IRQ}, 32'h18);
		@(posedge CLK);
		wr(8'h14, 32'hffffffff);
		rd(8'h14, 32'h0);
		rd(8'h08, 32'h28);
		rd(8'h04, 32'h1);
		rd(8'h10, 32'h0);
		rd(8'h0c, 32'h0);
		trip(2'h0, 1'b0, 2'h3);
		trip(2'h1, 1'b1, 2'h2);
		trip(2'h2, 1'b1, 2'h1);
		results;
	end
endmodule
